// ---- src/un9_defines.svh ----
// Register map, field positions, reset values and timing counts of the nine-bit serial core.
//
// Functional notes
// - In nine-bit mode a received address is ANDed with the match mask and compared with the match value; a full mask matches one address.
// - A control bit switches between normal framing and nine-bit multidrop framing; clearing it restores normal framing.
// - While break is set the serial output is held at the break level; clearing it hands the line back to the shifter, mid-frame if one is still running, else idle.
// - Busy stays high until the transmit FIFO is empty and the last stop bit has left the shift register.
// - A receive-data-available flag is high exactly while the receive FIFO holds a character.
// - Characters enter the transmit FIFO only while it has space, and a full flag lets the writer wait or retry.
// - A data read removes and returns the oldest received character, and emptiness is visible beforehand.
// - Software selects the baud clock source, system clock or internal oscillator, and can read the choice back.
// - Divisor and frame format read back so the real baud rate can be worked out.
// - The baud generator covers rates from zero up to a sixteenth of the supplied clock.
// - Frames have five to eight data bits, one or two stop bits, and none, even, odd, one or zero parity.
// - On disable the character in progress finishes and then the transmit FIFO is flushed.
// - In nine-bit mode an address character, marked as address, is sent after all queued data.
`ifndef UN9_DEFINES_SVH
`define UN9_DEFINES_SVH

`define UN9_ADDR_W      8
`define UN9_OFF_DATA    8'h00
`define UN9_OFF_STATUS  8'h04
`define UN9_OFF_CTRL    8'h08
`define UN9_OFF_DIV     8'h0C
`define UN9_OFF_MATCH   8'h10
`define UN9_OFF_ADDRTX  8'h14
`define UN9_OFF_INTST   8'h18
`define UN9_OFF_INTMSK  8'h1C

`define UN9_CTRL_W      10
`define UN9_CTRL_EN     0
`define UN9_CTRL_NINE   1
`define UN9_CTRL_BRK    2
`define UN9_CTRL_CLKSRC 3
`define UN9_CTRL_WLEN   5:4
`define UN9_CTRL_STOP2  6
`define UN9_CTRL_PAR    9:7
`define UN9_CTRL_RST    10'h030
`define UN9_DIV_RST     16'h0036
`define UN9_MASK_RST    8'hFF
`define UN9_VALUE_RST   8'h00

`define UN9_ST_BUSY     0
`define UN9_ST_RXAVAIL  1
`define UN9_ST_TXFULL   2
`define UN9_ST_RXEMPTY  3
`define UN9_ST_TXEMPTY  4
`define UN9_ST_ADDRPEND 5
`define UN9_DATA_EMPTY  31

`define UN9_INT_W       3
`define UN9_INT_RX      0
`define UN9_INT_TXDONE  1
`define UN9_INT_ADDR    2

`define UN9_SUB_MID     4'h7
`define UN9_SUB_LAST    4'hF
`define UN9_RESP_OKAY   2'h0
`define UN9_RESP_SLVERR 2'h2

`endif

// ---- src/un9_pkg.sv ----
// Types shared by the nine-bit serial core.
package un9_pkg;
  typedef enum logic [2:0] {
    UN9_PAR_NONE = 3'b000,
    UN9_PAR_EVEN = 3'b001,
    UN9_PAR_ODD  = 3'b010,
    UN9_PAR_ONE  = 3'b011,
    UN9_PAR_ZERO = 3'b100
  } un9_par_e;

  typedef enum logic [0:0] {
    UN9_TX_IDLE  = 1'b0,
    UN9_TX_SHIFT = 1'b1
  } un9_tx_e;

  typedef enum logic [1:0] {
    UN9_RX_IDLE  = 2'b00,
    UN9_RX_START = 2'b01,
    UN9_RX_SHIFT = 2'b10
  } un9_rx_e;
endpackage

// ---- src/un9_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
`timescale 1ns/10ps
module un9_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // System clock.
  input  wire logic             reset_n,   // Asynchronous reset, active low.
  input  wire logic             flush,     // Drops all contents.
  input  wire logic             in_valid,  // Writer offers a word.
  output logic                  in_ready,  // Space remains.
  input  wire logic [WIDTH-1:0] in_data,   // Word to store.
  output logic                  out_valid, // A word is held.
  input  wire logic             out_ready, // Reader takes the oldest word.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule

// ---- src/un9_core.sv ----
// Nine-bit multidrop serial transmitter and receiver with an AXI4-Lite register slave.
`timescale 1ns/10ps
`include "un9_defines.svh"
module un9_core #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  input  wire logic                   clk,       // System clock, 100 MHz.
  input  wire logic                   reset_n,   // Asynchronous reset, active low.
  input  wire logic [`UN9_ADDR_W-1:0] awaddr,    // Write address.
  input  wire logic                   awvalid,   // Write address valid.
  output logic                        awready,   // Write address ready.
  input  wire logic [31:0]            wdata,     // Write data.
  input  wire logic [3:0]             wstrb,     // Write byte strobes.
  input  wire logic                   wvalid,    // Write data valid.
  output logic                        wready,    // Write data ready.
  output logic [1:0]                  bresp,     // Write response.
  output logic                        bvalid,    // Write response valid.
  input  wire logic                   bready,    // Write response ready.
  input  wire logic [`UN9_ADDR_W-1:0] araddr,    // Read address.
  input  wire logic                   arvalid,   // Read address valid.
  output logic                        arready,   // Read address ready.
  output logic [31:0]                 rdata,     // Read data.
  output logic [1:0]                  rresp,     // Read response.
  output logic                        rvalid,    // Read data valid.
  input  wire logic                   rready,    // Read data ready.
  input  wire logic                   osc_tick,  // One pulse per internal oscillator period.
  input  wire logic                   rxd,       // Serial input.
  output logic                        txd,       // Serial output.
  output logic                        irq        // Interrupt, active high level.
);
  localparam int CTRL_W = `UN9_CTRL_W;

  logic [`UN9_CTRL_W-1:0] ctrl;
  logic [15:0]            divisor;
  logic [7:0]             match_address_value;
  logic [7:0]             match_address_mask;
  logic [`UN9_INT_W-1:0]  int_status;
  logic [`UN9_INT_W-1:0]  int_mask;
  logic                   aw_held;
  logic                   w_held;
  logic [`UN9_ADDR_W-1:0] aw_q;
  logic [31:0]            w_q;
  logic [3:0]             strb_q;
  logic                   do_wr;
  logic                   do_rd;
  logic [31:0]            rd_mux;
  logic                   rd_ok;
  logic                   addr_pending;
  logic [7:0]             pend_addr;
  logic [15:0]            bdiv_cnt;
  logic                   src_en;
  logic                   baud_tick;
  un9_pkg::un9_tx_e       tx_state;
  logic [12:0]            tx_sh;
  logic [3:0]             tx_left;
  logic [3:0]             tx_sub;
  un9_pkg::un9_rx_e       rx_state;
  logic [9:0]             rx_sh;
  logic [3:0]             rx_idx;
  logic [3:0]             rx_sub;
  logic                   rx_selected;
  logic                   rx_done;
  logic [7:0]             rx_char;
  logic                   rx_x;
  logic                   addr_hit;
  logic                   busy;
  logic                   busy_q;
  logic                   tx_in_valid;
  logic                   tx_in_ready;
  logic                   tx_out_valid;
  logic [8:0]             tx_out_data;
  logic                   tx_load;
  logic                   tx_flush;
  logic                   rx_in_valid;
  logic                   rx_in_ready;
  logic                   rx_out_valid;
  logic                   rx_out_ready;
  logic [8:0]             rx_out_data;
  logic [3:0]             payload;
  logic [3:0]             frame_len;
  logic [`UN9_INT_W-1:0]  int_set;

  wire logic             enable    = ctrl[`UN9_CTRL_EN];
  wire logic             nine_mode = ctrl[`UN9_CTRL_NINE];
  wire logic             break_control = ctrl[`UN9_CTRL_BRK];
  wire logic [1:0]       wlen      = ctrl[`UN9_CTRL_WLEN];
  wire un9_pkg::un9_par_e par_mode = un9_pkg::un9_par_e'(ctrl[`UN9_CTRL_PAR]);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] data_mask(input logic [1:0] wl);
    return 8'hFF >> (3'd3 - 3'(wl));
  endfunction

  // Bits between start and stop: data plus one parity or address-mark bit when parity or nine-bit mode is on.
  function automatic logic [3:0] payload_bits(input logic [1:0] wl, input logic nine,
                                              input un9_pkg::un9_par_e par);
    return 4'd5 + 4'(wl) + ((nine || par != un9_pkg::UN9_PAR_NONE) ? 4'd1 : 4'd0);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                   input un9_pkg::un9_par_e par);
    logic [7:0] md;
    md = d & data_mask(wl);
    case (par)
      un9_pkg::UN9_PAR_EVEN: return ^md;
      un9_pkg::UN9_PAR_ODD:  return ~^md;
      un9_pkg::UN9_PAR_ONE:  return 1'b1;
      default:               return 1'b0;
    endcase
  endfunction

  function automatic logic [12:0] build_frame(input logic [7:0] d, input logic [1:0] wl,
                                              input logic has_x, input logic xbit);
    logic [12:0] f;
    f    = 13'h1FFF;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 5 + int'(wl)) begin
        f[1+i] = d[i];
      end
    end
    if (has_x) begin
      f[6+int'(wl)] = xbit;
    end
    return f;
  endfunction

  assign payload   = payload_bits(wlen, nine_mode, par_mode);
  assign frame_len = 4'd2 + payload + (ctrl[`UN9_CTRL_STOP2] ? 4'd1 : 4'd0);

  // Write channel: address and data are taken independently, in either order.
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign do_wr   = aw_held && w_held && !bvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= '0;
      w_q     <= '0;
      strb_q  <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q    <= awaddr;
      end else if (do_wr) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q    <= wdata;
        strb_q <= wstrb;
      end else if (do_wr) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp  <= `UN9_RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      case (aw_q)
        `UN9_OFF_DATA, `UN9_OFF_CTRL, `UN9_OFF_DIV, `UN9_OFF_MATCH, `UN9_OFF_ADDRTX,
        `UN9_OFF_INTMSK: bresp <= `UN9_RESP_OKAY;
        default:         bresp <= `UN9_RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl                <= `UN9_CTRL_RST;
      divisor             <= `UN9_DIV_RST;
      match_address_value <= `UN9_VALUE_RST;
      match_address_mask  <= `UN9_MASK_RST;
      int_mask            <= '0;
    end else if (do_wr) begin
      case (aw_q)
        `UN9_OFF_CTRL:   ctrl <= CTRL_W'(merge(32'(ctrl), w_q, strb_q));
        `UN9_OFF_DIV:    divisor <= 16'(merge(32'(divisor), w_q, strb_q));
        `UN9_OFF_MATCH: begin
          if (strb_q[0]) begin
            match_address_value <= w_q[7:0];
          end
          if (strb_q[1]) begin
            match_address_mask <= w_q[15:8];
          end
        end
        `UN9_OFF_INTMSK: int_mask <= w_q[`UN9_INT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // An address request waits for the FIFO and shifter to drain; new data is held off meanwhile.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_pending <= 1'b0;
      pend_addr    <= '0;
    end else if (tx_flush) begin
      addr_pending <= 1'b0;
    end else if (tx_load && addr_pending && !tx_out_valid) begin
      addr_pending <= 1'b0;
    end else if (do_wr && aw_q == `UN9_OFF_ADDRTX && strb_q[0] && nine_mode) begin
      addr_pending <= 1'b1;
      pend_addr    <= w_q[7:0];
    end
  end

  // Read channel: one read in flight; a data read pops, an interrupt status read clears events.
  assign arready      = !rvalid;
  assign do_rd        = arvalid && arready;
  assign rx_out_ready = do_rd && araddr == `UN9_OFF_DATA;

  always_comb begin
    rd_mux = '0;
    rd_ok  = 1'b1;
    case (araddr)
      `UN9_OFF_DATA: begin
        rd_mux[8:0]             = rx_out_valid ? rx_out_data : 9'h000;
        rd_mux[`UN9_DATA_EMPTY] = !rx_out_valid;
      end
      `UN9_OFF_STATUS: begin
        rd_mux[`UN9_ST_BUSY]     = busy;
        rd_mux[`UN9_ST_RXAVAIL]  = rx_out_valid;
        rd_mux[`UN9_ST_TXFULL]   = !tx_in_ready || addr_pending;
        rd_mux[`UN9_ST_RXEMPTY]  = !rx_out_valid;
        rd_mux[`UN9_ST_TXEMPTY]  = !tx_out_valid;
        rd_mux[`UN9_ST_ADDRPEND] = addr_pending;
      end
      `UN9_OFF_CTRL:   rd_mux[`UN9_CTRL_W-1:0] = ctrl;
      `UN9_OFF_DIV:    rd_mux[15:0] = divisor;
      `UN9_OFF_MATCH:  rd_mux[15:0] = {match_address_mask, match_address_value};
      `UN9_OFF_INTST:  rd_mux[`UN9_INT_W-1:0] = int_status;
      `UN9_OFF_INTMSK: rd_mux[`UN9_INT_W-1:0] = int_mask;
      default:         rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `UN9_RESP_OKAY;
    end else if (do_rd) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_ok ? `UN9_RESP_OKAY : `UN9_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Events: a new event in the cycle of the clearing read still lands.
  assign int_set = {rx_in_valid && rx_in_ready && rx_x && nine_mode,
                    busy_q && !busy,
                    rx_in_valid && rx_in_ready};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_status <= '0;
      busy_q     <= 1'b0;
    end else begin
      busy_q <= busy;
      if (do_rd && araddr == `UN9_OFF_INTST) begin
        int_status <= int_set;
      end else begin
        int_status <= int_status | int_set;
      end
    end
  end

  assign irq = |(int_status & int_mask);

  // Baud generator: a zero divisor stops the line, divisor 1 gives clock/16.
  assign src_en    = ctrl[`UN9_CTRL_CLKSRC] ? osc_tick : 1'b1;
  assign baud_tick = src_en && divisor != 16'h0000 && bdiv_cnt >= divisor - 16'h0001;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bdiv_cnt <= '0;
    end else if (src_en) begin
      bdiv_cnt <= (baud_tick || divisor == 16'h0000) ? 16'h0000 : bdiv_cnt + 16'h0001;
    end
  end

  // Transmit FIFO and shifter.
  assign tx_in_valid = do_wr && aw_q == `UN9_OFF_DATA && strb_q[0] && !addr_pending;
  assign tx_flush    = !enable && tx_state == un9_pkg::UN9_TX_IDLE;
  assign tx_load     = tx_state == un9_pkg::UN9_TX_IDLE && enable && !break_control &&
                       (tx_out_valid || addr_pending);
  assign busy        = tx_out_valid || tx_state != un9_pkg::UN9_TX_IDLE || addr_pending;

  un9_fifo #(
    .WIDTH (9),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .flush     (tx_flush),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   ({1'b0, w_q[7:0]}),
    .out_valid (tx_out_valid),
    .out_ready (tx_load),
    .out_data  (tx_out_data)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= un9_pkg::UN9_TX_IDLE;
      tx_sh    <= 13'h1FFF;
      tx_left  <= '0;
      tx_sub   <= '0;
    end else begin
      case (tx_state)
        un9_pkg::UN9_TX_IDLE: begin
          tx_sub <= '0;
          if (tx_load) begin
            tx_state <= un9_pkg::UN9_TX_SHIFT;
            tx_left  <= frame_len;
            if (tx_out_valid) begin
              tx_sh <= build_frame(tx_out_data[7:0], wlen, nine_mode || par_mode !=
                       un9_pkg::UN9_PAR_NONE, nine_mode ? 1'b0 :
                       par_bit(tx_out_data[7:0], wlen, par_mode));
            end else begin
              tx_sh <= build_frame(pend_addr, wlen, 1'b1, 1'b1);
            end
          end
        end
        un9_pkg::UN9_TX_SHIFT: begin
          if (baud_tick) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == `UN9_SUB_LAST) begin
              tx_sh   <= {1'b1, tx_sh[12:1]};
              tx_left <= tx_left - 4'h1;
              if (tx_left == 4'h1) begin
                tx_state <= un9_pkg::UN9_TX_IDLE;
              end
            end
          end
        end
        default: tx_state <= un9_pkg::UN9_TX_IDLE;
      endcase
    end
  end

  // Break overrides the shifter; the frame underneath keeps its timing.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txd <= 1'b1;
    end else begin
      txd <= !break_control && (tx_state == un9_pkg::UN9_TX_IDLE || tx_sh[0]);
    end
  end

  // Receiver: start bit checked at mid-bit, then one sample per bit period.
  assign rx_char  = rx_sh[7:0] & data_mask(wlen);
  assign rx_x     = rx_sh[5+int'(wlen)];
  assign addr_hit = (rx_char & match_address_mask) == match_address_value;
  assign rx_done  = rx_state == un9_pkg::UN9_RX_SHIFT && baud_tick &&
                    rx_sub == `UN9_SUB_LAST && rx_idx == payload;
  assign rx_in_valid = rx_done && (!nine_mode || (rx_x ? addr_hit : rx_selected));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_selected <= 1'b0;
    end else if (!nine_mode) begin
      rx_selected <= 1'b0;
    end else if (rx_done && rx_x) begin
      rx_selected <= addr_hit;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= un9_pkg::UN9_RX_IDLE;
      rx_sh    <= '0;
      rx_idx   <= '0;
      rx_sub   <= '0;
    end else begin
      case (rx_state)
        un9_pkg::UN9_RX_IDLE: begin
          rx_sub <= '0;
          rx_idx <= '0;
          if (enable && !rxd && divisor != 16'h0000) begin
            rx_state <= un9_pkg::UN9_RX_START;
          end
        end
        un9_pkg::UN9_RX_START: begin
          if (baud_tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `UN9_SUB_MID) begin
              rx_sub   <= '0;
              rx_state <= rxd ? un9_pkg::UN9_RX_IDLE : un9_pkg::UN9_RX_SHIFT;
            end
          end
        end
        un9_pkg::UN9_RX_SHIFT: begin
          if (baud_tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `UN9_SUB_LAST) begin
              if (rx_idx == payload) begin
                rx_state <= un9_pkg::UN9_RX_IDLE;
              end else begin
                rx_sh[rx_idx] <= rxd;
                rx_idx        <= rx_idx + 4'h1;
              end
            end
          end
        end
        default: rx_state <= un9_pkg::UN9_RX_IDLE;
      endcase
    end
  end

  // A character arriving while the receive FIFO is full is lost.
  un9_fifo #(
    .WIDTH (9),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .flush     (1'b0),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   ({nine_mode && rx_x, rx_char}),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_out_data)
  );
endmodule

// ---- tb/un9_core_assertions.sv ----
// Bus handshake and serial bit timing checks for the nine-bit core.
`timescale 1ns/10ps
module un9_core_assertions (
  input wire logic clk,     // Clock.
  input wire logic reset_n, // Reset.
  input wire logic arvalid, // Bus.
  input wire logic arready, // Bus.
  input wire logic rvalid,  // Bus.
  input wire logic rready,  // Bus.
  input wire logic bvalid,  // Bus.
  input wire logic bready,  // Bus.
  input wire logic txd      // Line.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_b_holds: assert property (bvalid && !bready |=> bvalid) else $error("b lost");
  a_b_once: assert property (bvalid && bready |=> !bvalid) else $error("b twice");
  a_r_answer: assert property (arvalid && arready |=> rvalid) else $error("r late");
  a_r_holds: assert property (rvalid && !rready |=> rvalid) else $error("r lost");
  a_r_once: assert property (rvalid && rready |=> !rvalid) else $error("r twice");
  a_ar_blocked: assert property (rvalid |-> !arready) else $error("ar open");
  // No bit is shorter than sixteen clocks, so a level shorter than eight clocks is flagged as a glitch.
  a_low_len: assert property ($fell(txd) |-> !txd [*8]) else $error("short low");
  a_high_len: assert property ($rose(txd) |-> txd [*8]) else $error("short high");
endmodule

bind un9_core un9_core_assertions chk (.*);

// ---- tb/un9_line_model.sv ----
// Remote node: sends frames to the core and decodes what the core sends.
`timescale 1ns/10ps
module un9_line_model (
  input  wire logic       clk,    // Clock.
  input  wire logic       txd,    // From core.
  output logic            rxd,    // To core.
  output logic [8:0]      got,    // Heard char.
  output logic            got_stb // Heard pulse.
);
  initial {rxd, got_stb} = 2'b10;
  // Mid-bit sampling at one bit per sixteen clocks; the ninth sample is mark or stop.
  always begin
    @(negedge txd);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clk);
      got[i] <= txd;
    end
    got_stb <= 1'b1;
    @(posedge clk);
    got_stb <= 1'b0;
  end
  task automatic send(input logic [8:0] v, input logic nine);
    logic [10:0] f;
    f = {2'b11, v[7:0], 1'b0};
    if (nine) f[9] = v[8];
    for (int i = 0; i < 10 + nine; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge clk);
    end
  endtask
endmodule

// ---- tb/un9_core_tb.sv ----
// Bench for the nine-bit core: registers, transmit, receive, break, nine-bit.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module un9_core_tb;
  logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready, osc_tick;
  logic        awready, wready, bvalid, arready, rvalid, txd, rxd, irq, got_stb;
  logic [7:0]  awaddr, araddr, b;
  logic [3:0]  wstrb, ws;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [8:0]  got, sq[$];
  logic [33:0] rq[$];
  int          error_cnt, n_checks, seed, k;
  un9_core DUT (.*);
  un9_line_model m (.*);
  always #5 clk = ~clk;
  // The oscillator ticks at half the clock rate; its divisors are reckoned from that rate.
  always @(posedge clk) osc_tick <= ~osc_tick;
  always @(posedge clk) begin
    if (rvalid && rready) begin
      `CHK("read", rq[0], {rresp, rdata})
      rq.delete(0);
    end
    if (got_stb) begin
      `CHK("line", sq[0], got)
      sq.delete(0);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    {awvalid, wvalid} <= 2'b11;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    // Ready is raised late on purpose, so the response has to wait for it.
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {clk, reset_n, awvalid, wvalid, bready, arvalid, rready, osc_tick} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ws = 4'hF;
    seed = 67;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(8'h08, 34'h0_0000_0030);
    rd(8'h10, 34'h0_0000_FF00);
    rd(8'h20, 34'h2_0000_0000);
    wr(8'h08, 32'h0000_0039);
    rd(8'h08, 34'h0_0000_0039);
    wr(8'h08, 32'h0000_0031);
    wr(8'h0C, 32'h0000_0001);
    wr(8'h1C, 32'h0000_0002);
    b = 8'($random(seed));
    sq.push_back({1'b1, b});
    wr(8'h00, {24'h00_0000, b});
    for (k = 0; k < 3000 && !irq; k++) @(posedge clk);
    rd(8'h18, 34'h0_0000_0002);
    rd(8'h04, 34'h0_0000_0018);
    b = 8'($random(seed));
    m.send({1'b0, b}, 1'b0);
    `CHK("irq", 1'b0, irq)
    wr(8'h1C, 32'h0000_0001);
    `CHK("irq", 1'b1, irq)
    rd(8'h04, 34'h0_0000_0012);
    rd(8'h00, {26'h000_0000, b});
    rd(8'h00, 34'h0_8000_0000);
    // Break is held two full frames; the node decodes it as an all-zero char.
    sq.push_back(9'h000);
    wr(8'h08, 32'h0000_0035);
    repeat (320) @(posedge clk);
    `CHK("txd", 1'b0, txd)
    wr(8'h08, 32'h0000_0031);
    `CHK("txd", 1'b1, txd)
    wr(8'h08, 32'h0000_0033);
    wr(8'h10, 32'h0000_F050);
    m.send(9'h137, 1'b1);
    m.send(9'h011, 1'b1);
    m.send(9'h15A, 1'b1);
    m.send(9'h022, 1'b1);
    sq.push_back(9'h044);
    sq.push_back(9'h1A5);
    wr(8'h00, 32'h0000_0044);
    wr(8'h14, 32'h0000_00A5);
    for (k = 0; k < 3000 && sq.size() > 0; k++) @(posedge clk);
    rd(8'h00, 34'h0_0000_015A);
    rd(8'h00, 34'h0_0000_0022);
    // Seven data bits with even parity fill the same nine samples as an 8N1 frame.
    wr(8'h08, 32'h0000_00A1);
    b = 8'($random(seed));
    sq.push_back({1'b1, ^b[6:0], b[6:0]});
    wr(8'h00, {24'h00_0000, b});
    wr(8'h00, 32'h0000_0055);
    // The second character must be flushed, so the node hears only the first.
    wr(8'h08, 32'h0000_00A0);
    repeat (400) @(posedge clk);
    rd(8'h04, 34'h0_0000_0018);
    `CHK("line left", 0, sq.size())
    ws = 4'b0010;
    wr(8'h10, 32'h0000_AA11);
    ws = 4'hF;
    rd(8'h10, 34'h0_0000_AA50);
    end_of_test();
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule
